// >>> verilog/exec_defines.vh
// Constants for the branch, skip and control execution block.
// Included by the execution core and its register bank; definitions only.
`ifndef EXEC_DEFINES_VH
`define EXEC_DEFINES_VH

// Opcode group fields (upper nibble).
`define GRP_IDLE      4'h0
`define GRP_SHORT     4'h3
`define GRP_LATCH     4'h7
`define GRP_LONG      4'hC
`define GRP_SEL_PC    4'hD
`define GRP_SEL_IDX   4'hE

// Opcode digit fields (lower nibble).
`define DIG_IDLE      4'h0
`define DIG_SKIP1     4'h8
`define DIG_LATCH_OFF 4'hA
`define DIG_LATCH_ON  4'hB
`define DIG_NOP       4'h4

// Reset values.
`define RST_LATCH     1'b0
`define RST_SEL       4'h0
`define RST_WORD      16'h0000

// Cycle counts of a long instruction: one fetch, two execute.
`define LONG_EXEC_CYCLES 2'h2

`endif

// >>> verilog/pointer_bank.v
// Sixteen 16-bit scratch pointers with one write port and two read ports.
// Assumes a single writer per cycle from the execution core.
`include "exec_defines.vh"
`timescale 1ns/10ps
module pointer_bank #(
	parameter WIDTH = 16,
	parameter COUNT = 16
) (
	input  wire               ref_clk,
	input  wire               arst_n,
	input  wire               wr_en,
	input  wire [3:0]         wr_idx,
	input  wire [WIDTH-1:0]   wr_data,
	input  wire [3:0]         rd_a_idx,
	output wire [WIDTH-1:0]   rd_a_data,
	input  wire [3:0]         rd_b_idx,
	output wire [WIDTH-1:0]   rd_b_data
);
	reg [WIDTH-1:0] word_ff [0:COUNT-1];
	genvar g;

	generate
		for (g = 0; g < COUNT; g = g + 1) begin : gen_word
			always @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n)
					word_ff[g] <= `RST_WORD;
				else if (wr_en && wr_idx == g)
					word_ff[g] <= wr_data;
			end
		end
	endgenerate

	assign rd_a_data = word_ff[rd_a_idx];
	assign rd_b_data = word_ff[rd_b_idx];
endmodule // pointer_bank

// >>> verilog/branch_skip_control_exec.v
// Fetch/execute sequencer for long branches, skips and control instructions.
// Assumes program memory answers combinationally to mem_addr, and that the
// accumulator, carry_flag and interrupt_enable come from the rest of the core.
//
// Summary of operation
// - CA jumps long when accumulator nonzero
// - C3 jumps on carry, CB on no carry
// - C1 jumps on latch, C9 on no latch
// - Long instructions take fetch plus two executes
// - 38 skips one following byte
// - C8 skips two following bytes
// - Conditional long skips skip two when true
// - False long skip continues after opcode
// - 00 idles, driving memory at pointer zero
// - Acknowledged request ends idle, then resumes
// - C4 does nothing in three cycles
// - DN loads counter selector, jumps there
// - EN loads operand selector
// - 7B sets output latch
// - 7A clears output latch
// - Reset clears output latch
`include "exec_defines.vh"
`timescale 1ns/10ps
module branch_skip_control_exec #(
	parameter AW = 16
) (
	input  wire          ref_clk,
	input  wire          arst_n,
	input  wire [7:0]    mem_rdata,
	output reg  [AW-1:0] mem_addr,
	output reg  [7:0]    bus_data,
	output reg           bus_drive,
	input  wire [7:0]    accumulator,
	input  wire          carry_flag,
	input  wire          interrupt_enable,
	input  wire          irq_req,
	input  wire          dma_in_req,
	input  wire          dma_out_req,
	output reg           request_ack,
	input  wire          service_done,
	output reg           latch_q,
	output reg  [3:0]    counter_sel,
	output reg  [3:0]    operand_sel,
	output reg  [7:0]    opcode_ff,
	output reg           fetch_cycle,
	output reg           exec_cycle
);
	// -------------------------------------------------------------------
	// States
	// -------------------------------------------------------------------
	localparam ST_FETCH = 5'b00001;
	localparam ST_EXEC1 = 5'b00010;
	localparam ST_EXEC2 = 5'b00100;
	localparam ST_IDLE  = 5'b01000;
	localparam ST_SERV  = 5'b10000;

	reg  [4:0]    state_ff;
	reg  [4:0]    nxt_state;
	reg  [7:0]    hi_byte_ff;
	reg  [7:0]    nxt_hi_byte;
	reg  [7:0]    nxt_opcode;
	reg           nxt_latch;
	reg  [3:0]    nxt_counter_sel;
	reg  [3:0]    nxt_operand_sel;
	reg           wr_en;
	reg  [AW-1:0] wr_data;
	reg           req_pending;
	wire [AW-1:0] pc;
	wire [AW-1:0] ptr0;
	wire [3:0]    grp;
	wire [3:0]    dig;

	assign grp = opcode_ff[7:4];
	assign dig = opcode_ff[3:0];

	// -------------------------------------------------------------------
	// Decoding helpers
	// -------------------------------------------------------------------
	// Digit bit 3 inverts the sense; bits 1:0 pick the tested flag.
	function cond_true;
		input [3:0] d;
		input [7:0] acc;
		input       cy;
		input       q;
		reg         base;
		begin
			base = 1'b0;
			case (d[1:0])
				2'b00: base = 1'b1;
				2'b01: base = q;
				2'b10: base = (acc == 8'h00);
				default: base = cy;
			endcase
			cond_true = base ^ d[3];
		end
	endfunction

	// Skip forms test with inverted polarity and carry digits C and 4 as the
	// interrupt-enable test and the do-nothing code.
	function skip_true;
		input [3:0] d;
		input [7:0] acc;
		input       cy;
		input       q;
		input       ie;
		begin
			case (d)
				4'hE:    skip_true = (acc == 8'h00);
				4'h6:    skip_true = (acc != 8'h00);
				4'hF:    skip_true = cy;
				4'h7:    skip_true = ~cy;
				4'hD:    skip_true = q;
				4'h5:    skip_true = ~q;
				4'hC:    skip_true = ie;
				4'h8:    skip_true = 1'b1;
				default: skip_true = 1'b0;
			endcase
		end
	endfunction

	// Digit bit 2 set, or digit 8, marks the skip forms of group C.
	function is_skip_form;
		input [3:0] d;
		begin
			is_skip_form = d[2] | (d == 4'h8);
		end
	endfunction

	pointer_bank #(
		.WIDTH (AW),
		.COUNT (16)
	) u_bank (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.wr_en     (wr_en),
		.wr_idx    (counter_sel),
		.wr_data   (wr_data),
		.rd_a_idx  (nxt_counter_sel),
		.rd_a_data (pc),
		.rd_b_idx  (4'h0),
		.rd_b_data (ptr0)
	);

	// -------------------------------------------------------------------
	// Sequencer
	// -------------------------------------------------------------------
	// The bank is indexed by the next selector so that a selector load takes
	// effect on the very next fetch address without a dead cycle.
	always @* begin
		nxt_state       = state_ff;
		nxt_opcode      = opcode_ff;
		nxt_hi_byte     = hi_byte_ff;
		nxt_latch       = latch_q;
		nxt_counter_sel = counter_sel;
		nxt_operand_sel = operand_sel;
		wr_en           = 1'b0;
		wr_data         = pc;
		req_pending     = irq_req | dma_in_req | dma_out_req;
		case (state_ff)
			ST_FETCH: begin
				nxt_opcode = mem_rdata;
				wr_en      = 1'b1;
				wr_data    = pc + {{(AW-1){1'b0}}, 1'b1};
				nxt_state  = ST_EXEC1;
			end
			ST_EXEC1: begin
				nxt_state = ST_FETCH;
				case (grp)
					`GRP_IDLE: begin
						if (dig == `DIG_IDLE)
							nxt_state = ST_IDLE;
					end
					`GRP_SHORT: begin
						if (dig == `DIG_SKIP1) begin
							wr_en   = 1'b1;
							wr_data = pc + {{(AW-1){1'b0}}, 1'b1};
						end
					end
					`GRP_LATCH: begin
						if (dig == `DIG_LATCH_ON)
							nxt_latch = 1'b1;
						else if (dig == `DIG_LATCH_OFF)
							nxt_latch = 1'b0;
					end
					`GRP_LONG: begin
						nxt_state = ST_EXEC2;
						if (!is_skip_form(dig) &&
						    cond_true(dig, accumulator, carry_flag, latch_q)) begin
							nxt_hi_byte = mem_rdata;
							wr_en       = 1'b1;
							wr_data     = pc + {{(AW-1){1'b0}}, 1'b1};
						end
					end
					`GRP_SEL_PC: begin
						nxt_counter_sel = dig;
					end
					`GRP_SEL_IDX: begin
						nxt_operand_sel = dig;
					end
					default: begin
					end
				endcase
			end
			ST_EXEC2: begin
				nxt_state = ST_FETCH;
				if (is_skip_form(dig)) begin
					if (skip_true(dig, accumulator, carry_flag, latch_q, interrupt_enable)) begin
						wr_en   = 1'b1;
						wr_data = pc + {{(AW-2){1'b0}}, 2'b10};
					end
				end else if (cond_true(dig, accumulator, carry_flag, latch_q)) begin
					wr_en   = 1'b1;
					wr_data = {hi_byte_ff, mem_rdata};
				end else begin
					wr_en   = 1'b1;
					wr_data = pc + {{(AW-2){1'b0}}, 2'b10};
				end
			end
			ST_IDLE: begin
				if (req_pending)
					nxt_state = ST_SERV;
			end
			ST_SERV: begin
				if (service_done)
					nxt_state = ST_FETCH;
			end
			default: nxt_state = ST_FETCH;
		endcase
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff    <= ST_FETCH;
			opcode_ff   <= 8'h00;
			hi_byte_ff  <= 8'h00;
			latch_q     <= `RST_LATCH;
			counter_sel <= `RST_SEL;
			operand_sel <= `RST_SEL;
			mem_addr    <= {AW{1'b0}};
			bus_data    <= 8'h00;
			bus_drive   <= 1'b0;
			request_ack <= 1'b0;
			fetch_cycle <= 1'b1;
			exec_cycle  <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			opcode_ff   <= nxt_opcode;
			hi_byte_ff  <= nxt_hi_byte;
			latch_q     <= nxt_latch;
			counter_sel <= nxt_counter_sel;
			operand_sel <= nxt_operand_sel;
			fetch_cycle <= (nxt_state == ST_FETCH);
			exec_cycle  <= (nxt_state == ST_EXEC1) | (nxt_state == ST_EXEC2) | (nxt_state == ST_IDLE);
			request_ack <= (state_ff == ST_IDLE) && req_pending;
			bus_drive   <= (nxt_state == ST_IDLE);
			bus_data    <= mem_rdata;
			// Pointer zero is addressed while idling; the counter otherwise.
			if (nxt_state == ST_IDLE)
				mem_addr <= ptr0;
			else if (wr_en && nxt_counter_sel == counter_sel)
				mem_addr <= wr_data;
			else
				mem_addr <= pc;
		end
	end
endmodule // branch_skip_control_exec

// >>> verif/exec_checker_properties.sv
// Port checks for the branch, skip and control sequencer.
// Bound from the bench top; sees only the sequencer's ports.
`timescale 1ns/10ps
module exec_checker (
	input wire       ref_clk,
	input wire       arst_n,
	input wire       request_ack,
	input wire       bus_drive,
	input wire       latch_q,
	input wire [3:0] counter_sel,
	input wire [3:0] operand_sel,
	input wire [7:0] opcode_ff,
	input wire       fetch_cycle,
	input wire       exec_cycle
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	latch_reset_a: assert property (disable iff (1'b0) !arst_n |-> !latch_q)
		else $error("latch set in reset");
	latch_set_a: assert property ($rose(latch_q) |-> opcode_ff == 8'h7B)
		else $error("latch rose");
	latch_clear_a: assert property ($fell(latch_q) |-> opcode_ff == 8'h7A)
		else $error("latch fell");
	long_length_a: assert property ($rose(exec_cycle) && opcode_ff[7:4] == 4'hC |=> exec_cycle ##1 fetch_cycle)
		else $error("long length");
	short_length_a: assert property ($rose(exec_cycle) && opcode_ff[7:4] == 4'h7 |=> fetch_cycle)
		else $error("short length");
	ack_pulse_a: assert property (request_ack |-> opcode_ff == 8'h00 ##1 !request_ack)
		else $error("ack");
	idle_bus_a: assert property (bus_drive |-> opcode_ff == 8'h00 && !fetch_cycle)
		else $error("bus drive");
	operand_sel_a: assert property ($changed(operand_sel) |-> opcode_ff[7:4] == 4'hE)
		else $error("operand sel");
	counter_sel_a: assert property ($changed(counter_sel) |-> opcode_ff[7:4] == 4'hD)
		else $error("counter sel");
	one_phase_a: assert property (!(fetch_cycle && exec_cycle))
		else $error("phase");
endmodule // exec_checker

// >>> verif/prog_mem.sv
// Program memory model answering combinationally to the sequencer.
// The bench loads mem before reset, and reloads only bytes not being fetched.
`timescale 1ns/10ps
module prog_mem (
	input  wire [15:0] mem_addr,
	output wire [7:0]  mem_rdata
);
	reg [7:0] mem [0:255];
	// Outside the loaded page a filler opcode shows any stray jump.
	assign mem_rdata = (mem_addr[15:8] == 8'h00) ? mem[mem_addr[7:0]] : 8'hE9;
endmodule // prog_mem

// >>> verif/tb_top.sv
// Self-checking bench for the sequencer: follows the fetched opcodes.
// Assumes the program memory model answers combinationally.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
	reg ref_clk = 0, arst_n = 0, irq_req = 0, service_done = 0;
	wire [15:0] mem_addr;
	wire [7:0] mem_rdata, bus_data, opcode_ff;
	wire [3:0] counter_sel, operand_sel;
	wire bus_drive, request_ack, latch_q, fetch_cycle, exec_cycle;
	int mismatches = 0, n_tests = 0, i;
	reg [7:0] op;
	reg [7:0] acc = 8'h01;
	reg carry = 0, ie = 0, dma_in_req = 0;
	reg [63:0] exp2 = {8'hCA, 8'hC3, 8'hCB, 8'hCF, 8'hC7, 8'hCC, 8'hC6, 8'h00};
	reg [159:0] exp_ops = {8'h7B, 8'hC1, 8'hCD, 8'h7A, 8'hC1, 8'hC9, 8'h38, 8'hC8, 8'hC5, 8'hCE,
		8'hE3, 8'hC4, 8'hCA, 8'hC3, 8'hCB, 8'hC6, 8'hCF, 8'hC7, 8'hCC, 8'h00};
	always #5 ref_clk = ~ref_clk;
	prog_mem i_prog_mem (.mem_addr(mem_addr), .mem_rdata(mem_rdata));
	branch_skip_control_exec i_branch_skip_control_exec (.ref_clk(ref_clk), .arst_n(arst_n),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .bus_data(bus_data), .bus_drive(bus_drive),
		.accumulator(acc), .carry_flag(carry), .interrupt_enable(ie), .irq_req(irq_req),
		.dma_in_req(dma_in_req), .dma_out_req(1'b0), .request_ack(request_ack),
		.service_done(service_done), .latch_q(latch_q), .counter_sel(counter_sel),
		.operand_sel(operand_sel), .opcode_ff(opcode_ff), .fetch_cycle(fetch_cycle),
		.exec_cycle(exec_cycle));
	task ld(input [7:0] a, input [31:0] w);
		for (int k = 0; k < 4; k++) i_prog_mem.mem[a + k] = w[31 - 8 * k -: 8];
	endtask
	// Waits for a fetch cycle, then takes the opcode it latched.
	task next_op(output [7:0] o);
		int k;
		k = 0;
		while (fetch_cycle !== 1'b1 && k < 50) begin
			@(posedge ref_clk);
			#1 k++;
		end
		@(posedge ref_clk);
		#1 o = opcode_ff;
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#10000 mismatches++;
		end_of_test;
	end
	initial begin
		for (i = 0; i < 256; i++) i_prog_mem.mem[i] = 8'hE9;
		ld(8'h00, 32'h7BC10010); ld(8'h10, 32'hCDE9E97A); ld(8'h14, 32'hC15555C9);
		ld(8'h18, 32'h0020E9E9); ld(8'h20, 32'h38E9C8E9); ld(8'h24, 32'hE9C5E9E9);
		ld(8'h28, 32'hCEE3C4CA); ld(8'h2C, 32'h0030E9E9); ld(8'h30, 32'hC3E9E9CB);
		ld(8'h34, 32'h0040E9E9); ld(8'h40, 32'hC6E9E9CF); ld(8'h44, 32'hC7E9E9CC);
		ld(8'h48, 32'h00D1A5E9);
		repeat (5) @(posedge ref_clk);
		#1 `CHK(latch_q, 1'b0)
		arst_n = 1;
		for (i = 0; i < 20; i++) begin
			next_op(op);
			`CHK(op, exp_ops[159 - 8 * i -: 8])
		end
		`CHK(operand_sel, 4'h3)
		`CHK(latch_q, 1'b0)
		repeat (3) @(posedge ref_clk);
		#1 `CHK(bus_drive, 1'b1)
		`CHK(bus_data, 8'hD1)
		irq_req = 1;
		// Second pass flips the accumulator, carry and interrupt-enable inputs and reloads the low page while idling at 49.
		acc = 8'h00;
		carry = 1;
		ie = 1;
		ld(8'h00, 32'hCEE9E9CA); ld(8'h04, 32'hE9E9C300); ld(8'h08, 32'h0CE9E9E9);
		ld(8'h0C, 32'hCBE9E9CF); ld(8'h10, 32'hE9E9C7CC); ld(8'h14, 32'hE9E9C600);
		for (i = 0; i < 20 && request_ack !== 1'b1; i++) @(posedge ref_clk) #1;
		`CHK(request_ack, 1'b1)
		@(posedge ref_clk);
		#1 irq_req = 0;
		service_done = 1;
		@(posedge ref_clk);
		#1 service_done = 0;
		next_op(op);
		`CHK(op, 8'hD1)
		next_op(op);
		`CHK(counter_sel, 4'h1)
		`CHK(op, 8'hCE)
		for (i = 0; i < 8; i++) begin
			next_op(op);
			`CHK(op, exp2[63 - 8 * i -: 8])
		end
		repeat (3) @(posedge ref_clk);
		#1 `CHK(bus_drive, 1'b1)
		`CHK(bus_data, 8'hA5)
		dma_in_req = 1;
		for (i = 0; i < 20 && request_ack !== 1'b1; i++) @(posedge ref_clk) #1;
		`CHK(request_ack, 1'b1)
		end_of_test;
	end
endmodule // tb_top
bind branch_skip_control_exec exec_checker i_exec_checker (.ref_clk(ref_clk), .arst_n(arst_n),
	.request_ack(request_ack), .bus_drive(bus_drive), .latch_q(latch_q), .counter_sel(counter_sel),
	.operand_sel(operand_sel), .opcode_ff(opcode_ff), .fetch_cycle(fetch_cycle), .exec_cycle(exec_cycle));
